// file: rtl/spd_consts.svh
// Constants for the special register page decoder
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH
`define SPD_PAGE_SELECT_ADDR 8'hbf
`define SPD_PAGE_SELECT_RESET 8'h00
`define SPD_SPACE_BASE 8'h80
`define SPD_PAGE_ZERO 8'h00
`define SPD_PAGE_F 8'h0f
`define SPD_BIT_NIBBLE_A 3'h0
`define SPD_BANK_COUNT 2
`endif

// file: rtl/spd_pkg.sv
// Types for the special register page decoder
package spd_pkg;
    // Core access request on the direct address bus
    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_op;
        logic [7:0] addr;
        logic [2:0] bit_idx;
        logic [7:0] wdata;
        logic wbit;
    } spd_req_t;
    // Decoded select toward the register banks
    typedef struct packed {
        logic sel_common;
        logic sel_page0;
        logic sel_pagef;
        logic rd;
        logic wr;
        logic bit_op;
        logic [6:0] offset;
        logic [7:0] wdata;
        logic [7:0] wmask;
    } spd_sel_t;
endpackage

// file: rtl/spd_page_decoder.sv
// Page select register and address decode for the special register space
// Behaviour
// - Page selector is eight bits, any value.
// - Page and address 0x80-0xFF form decode.
// - Only pages 0x0 and 0xF are populated.
// - Common registers answer on both populated pages.
// - Page write affects all later accesses.
// - Page register read returns full page.
// - Page register at 0xBF on every page.
// - Low nibble 0x0/0x8 allows bit access.
// - Undefined combinations map to nothing.
// - Decode only for direct addresses 0x80-0xFF.
`timescale 1ns/1ps
`include "spd_consts.svh"
module spd_page_decoder
    import spd_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input spd_req_t req,
    input wire logic [7:0] rdata_common,
    input wire logic [7:0] rdata_page0,
    input wire logic [7:0] rdata_pagef,
    output spd_sel_t sel,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic [7:0] page_select
);
    // Offset classes used to build the occupancy maps
    localparam logic [1:0] KIND_COMMON = 2'h0;
    localparam logic [1:0] KIND_PAGED = 2'h1;
    localparam logic [1:0] KIND_HOLE = 2'h2;
    localparam logic [1:0] KIND_PAGE_REG = 2'h3;

    // Occupancy of the space by row, offset = address - 0x80:
    //   0x80-0x87 common on both pages
    //   0x88-0x8f common on both pages
    //   0x90 common; 0x91-0x95 paged; 0x96-0x97 common
    //   0x98-0x9f common on both pages
    //   0xa0-0xa7 common on both pages
    //   0xa8-0xaf common, holes at 0xab and 0xad
    //   0xb0-0xb7 common on both pages
    //   0xb8 common; 0xb9 paged; 0xba-0xbe common; 0xbf page select
    //   0xc0-0xc2 paged; 0xc3-0xc7 common
    //   0xc8-0xcf paged
    //   0xd0-0xd7 common on both pages
    //   0xd8-0xdf common on both pages
    //   0xe0-0xe3 common; 0xe4 paged; 0xe5-0xe7 common
    //   0xe8-0xef common on both pages
    //   0xf0-0xf7 common on both pages
    //   0xf8-0xff common on both pages
    // A paged offset holds one register on page 0x0 and another on page 0xf.

    // Class of one offset; a hole never maps to a bank
    function automatic logic [1:0] offset_kind(input logic [6:0] o);
        logic [1:0] k;
        k = KIND_COMMON;
        case (o)
            7'h11: k = KIND_PAGED; // Timer control pair
            7'h12: k = KIND_PAGED;
            7'h13: k = KIND_PAGED;
            7'h14: k = KIND_PAGED;
            7'h15: k = KIND_PAGED;
            7'h2b: k = KIND_HOLE;
            7'h2d: k = KIND_HOLE;
            7'h39: k = KIND_PAGED;
            7'h3f: k = KIND_PAGE_REG;
            7'h40: k = KIND_PAGED; // Two-wire unit pair
            7'h41: k = KIND_PAGED;
            7'h42: k = KIND_PAGED;
            7'h48: k = KIND_PAGED; // Timer pair
            7'h49: k = KIND_PAGED;
            7'h4a: k = KIND_PAGED;
            7'h4b: k = KIND_PAGED;
            7'h4c: k = KIND_PAGED;
            7'h4d: k = KIND_PAGED;
            7'h4e: k = KIND_PAGED;
            7'h4f: k = KIND_PAGED;
            7'h64: k = KIND_PAGED;
            default: k = KIND_COMMON;
        endcase
        return k;
    endfunction

    // Occupancy maps, one bit per offset, fixed at elaboration
    logic [127:0] common_map;
    logic [127:0] page0_map;
    logic [127:0] pagef_map;
    for (genvar g = 0; g < 128; g++) begin : g_offset
        localparam logic [1:0] KIND = offset_kind(7'(g));
        assign common_map[g] = (KIND == KIND_COMMON);
        assign page0_map[g] = (KIND == KIND_PAGED);
        assign pagef_map[g] = (KIND == KIND_PAGED);
    end

    // Address lies in the special register space
    logic in_space;
    // Address is the page select register
    logic is_page_reg;
    // Offset inside the space
    logic [6:0] off;
    // Current page is one of the populated ones
    logic page_is_0;
    logic page_is_f;
    // Bank hits for the current request
    logic hit_common;
    logic hit_0;
    logic hit_f;
    // Bit operation is legal at this address
    logic bit_ok;
    // Byte lane mask toward the banks
    logic [7:0] mask;
    // Next values of the registered outputs
    logic [7:0] next_rdata;
    spd_sel_t next_sel;

    // Address classification
    assign in_space = req.addr[7];
    assign off = req.addr[6:0];
    assign is_page_reg = in_space && (req.addr == `SPD_PAGE_SELECT_ADDR);
    assign page_is_0 = (page_select == `SPD_PAGE_ZERO);
    assign page_is_f = (page_select == `SPD_PAGE_F);
    assign hit_common = in_space && !is_page_reg && common_map[off]
        && (page_is_0 || page_is_f);
    assign hit_0 = in_space && page_is_0 && page0_map[off];
    assign hit_f = in_space && page_is_f && pagef_map[off];
    assign bit_ok = (req.addr[2:0] == `SPD_BIT_NIBBLE_A);

    // Write mask: one lane for a legal bit operation, all lanes otherwise
    for (genvar b = 0; b < 8; b++) begin : g_mask
        assign mask[b] = !(req.bit_op && bit_ok) || (req.bit_idx == 3'(b));
    end

    // Page select register, written at once for all later accesses.
    // Handlers that touch paged registers must put the page back on exit,
    // the register itself keeps no history.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            page_select <= `SPD_PAGE_SELECT_RESET;
        end else if (req.wr && is_page_reg) begin
            if (req.bit_op) begin
                page_select <= page_select;
            end else begin
                page_select <= req.wdata;
            end
        end
    end

    // Selects toward the banks; bit ops off 0x0/0x8 are dropped
    always_comb begin
        next_sel = '0;
        next_sel.sel_common = hit_common;
        next_sel.sel_page0 = hit_0;
        next_sel.sel_pagef = hit_f;
        next_sel.rd = req.rd && (!req.bit_op || bit_ok);
        next_sel.wr = req.wr && (!req.bit_op || bit_ok);
        next_sel.bit_op = req.bit_op && bit_ok;
        next_sel.offset = off;
        next_sel.wdata = req.bit_op ? {8{req.wbit}} : req.wdata;
        next_sel.wmask = mask;
    end

    // Registered selects
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sel <= '0;
        end else begin
            sel <= next_sel;
        end
    end

    // Read return: page register, selected bank, or zero for reserved
    always_comb begin
        next_rdata = 8'h00;
        if (req.rd) begin
            if (is_page_reg) begin
                next_rdata = page_select;
            end else if (hit_common) begin
                next_rdata = rdata_common;
            end else if (hit_0) begin
                next_rdata = rdata_page0;
            end else if (hit_f) begin
                next_rdata = rdata_pagef;
            end
        end
    end

    // Registered read data
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Every read in the space is answered one cycle later
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd && in_space;
        end
    end
endmodule

// file: sim/spd_page_decoder_properties.sv
// Port checker for the page decoder
`timescale 1ns/1ps
module spd_page_decoder_properties
    import spd_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input spd_req_t req,
    input spd_sel_t sel,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic [7:0] page_select
);
default clocking @(posedge core_clk); endclocking
default disable iff (!resetn);
property p_rv; req.rd && req.addr[7] |=> rvalid; endproperty
a_rv: assert property (p_rv) else $error("read not answered");
property p_nv; !(req.rd && req.addr[7]) |=> !rvalid; endproperty
a_nv: assert property (p_nv) else $error("stray answer");
property p_pw; req.wr && !req.bit_op && req.addr == 8'hbf |=> page_select == $past(req.wdata); endproperty
a_pw: assert property (p_pw) else $error("page not written");
property p_ps; !(req.wr && req.addr == 8'hbf) |=> $stable(page_select); endproperty
a_ps: assert property (p_ps) else $error("page moved");
property p_pr; req.rd && !req.wr && req.addr == 8'hbf |=> rdata == page_select; endproperty
a_pr: assert property (p_pr) else $error("page readback");
property p_z; req.rd && req.addr[7] && req.addr != 8'hbf && page_select != 8'h00
    && page_select != 8'h0f |=> rdata == 8'h00; endproperty
a_z: assert property (p_z) else $error("empty page data");
property p_f; req.rd && req.addr == 8'hc0 && page_select == 8'h0f |=> sel.sel_pagef && !sel.sel_page0; endproperty
a_f: assert property (p_f) else $error("page f select");
property p_lo; (req.rd || req.wr) && !req.addr[7] |=> !(sel.sel_common || sel.sel_page0 || sel.sel_pagef); endproperty
a_lo: assert property (p_lo) else $error("low address select");
endmodule

// file: sim/spd_bank_model.sv
// Bank read data stand-in for the far side
`timescale 1ns/1ps
module spd_bank_model
    import spd_pkg::*;
(
    input spd_req_t req,
    output logic [7:0] rdata_common,
    output logic [7:0] rdata_page0,
    output logic [7:0] rdata_pagef
);
// Distinct pattern per bank so a wrong select shows
assign rdata_common = req.addr ^ 8'h11;
assign rdata_page0 = req.addr ^ 8'h22;
assign rdata_pagef = req.addr ^ 8'h33;
endmodule

// file: sim/spd_page_decoder_tb.sv
// Bench for the page decoder
`timescale 1ns/1ps
module spd_page_decoder_tb
    import spd_pkg::*;
;
logic core_clk = 0, resetn = 0, rv;
spd_req_t req = '0;
logic [7:0] rc, r0, rf, rd, pg, p, a;
spd_sel_t sel;
int failures = 0, tests_run = 0, seed = 3186, cyc = 0;
spd_bank_model spd_bank_model_i(.req(req), .rdata_common(rc), .rdata_page0(r0), .rdata_pagef(rf));
spd_page_decoder spd_page_decoder_i(.core_clk(core_clk), .resetn(resetn), .req(req),
    .rdata_common(rc), .rdata_page0(r0), .rdata_pagef(rf), .sel(sel), .rdata(rd),
    .rvalid(rv), .page_select(pg));
initial forever #5 core_clk = ~core_clk;
// Hang guard
always @(posedge core_clk) if (++cyc == 3000) begin failures++; results(); end
task results;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin failures++; $display("FAIL t=%0t seen=%h exp=%h", $time, s, e); end
endtask
// One access, sampled just after the edge that takes it
task acc(input logic r, input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    req.rd <= r; req.wr <= !r; req.addr <= ad; req.wdata <= d;
    @(posedge core_clk);
    #1;
endtask
function logic [7:0] ex(input logic [7:0] ad, input logic [7:0] pp);
    if (ad == 8'hbf) return pp;
    if (pp != 8'h00 && pp != 8'h0f) return 8'h00;
    if (ad == 8'hc0) return ad ^ (pp == 8'h0f ? 8'h33 : 8'h22);
    return ad ^ 8'h11;
endfunction
initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1;
    #1 chk(pg, 8'h00);
    for (int i = 0; i < 40; i++) begin
        p = i[1] ? (8'($random(seed)) | 8'h10) : {4'h0, {4{i[0]}}};
        a = i[1] ? (8'($random(seed)) | 8'h80) : (i[2] ? 8'hc0 : 8'h80);
        acc(0, 8'hbf, p); chk(pg, p);
        acc(1, 8'hbf, 8'h00); chk(rd, p);
        acc(1, a, 8'h00); chk(rd, ex(a, p));
        chk({7'h0, rv}, 8'h01);
        acc(1, a & 8'h7f, 8'h00); chk({7'h0, rv}, 8'h00);
    end
    acc(0, 8'hbf, 8'h00); chk(pg, 8'h00);
    acc(1, 8'hab, 8'h00); chk(rd, 8'h00);
    acc(1, 8'hb9, 8'h00);
    chk({5'h0, sel.sel_common, sel.sel_page0, sel.sel_pagef}, 8'h02);
    acc(1, 8'hbf, 8'h00); p = rd;
    acc(0, 8'hbf, 8'h0f); acc(1, 8'he4, 8'h00); chk(rd, 8'he4 ^ 8'h33);
    acc(0, 8'hbf, p); chk(pg, 8'h00);
    req.bit_op <= 1; req.bit_idx <= 3'h5; req.wbit <= 1;
    acc(0, 8'h88, 8'h00); chk(sel.wmask, 8'h20);
    chk({7'h0, sel.wr}, 8'h01);
    acc(0, 8'h89, 8'h00); chk({7'h0, sel.wr}, 8'h00);
    acc(0, 8'hbf, 8'h55); chk(pg, 8'h00);
    req.bit_op <= 0;
    results();
end
endmodule
bind spd_page_decoder spd_page_decoder_properties spd_page_decoder_properties_i(
    .core_clk(core_clk), .resetn(resetn), .req(req), .sel(sel), .rdata(rdata),
    .rvalid(rvalid), .page_select(page_select));
